// ===== rtl/hise_cfg_hdr.sv
// configuration header: identity codes and two memory base address regions
`timescale 1ns/100ps
module hise_cfg_hdr (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_off,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic [31:0] bar0_base,
  output logic [31:0] bar1_base
);

  logic [31:0] bar0_r;
  logic [31:0] bar0_nxt;
  logic [31:0] bar1_r;
  logic [31:0] bar1_nxt;

  always_comb begin
    bar0_nxt = bar0_r;
    bar1_nxt = bar1_r;
    // size probe reads back the region mask
    if (cfg_wr) begin
      if (cfg_off == hise_pkg::CFG_OFF_BAR0) begin
        bar0_nxt = cfg_wdata & hise_pkg::BAR0_MASK;
      end else if (cfg_off == hise_pkg::CFG_OFF_BAR1) begin
        bar1_nxt = cfg_wdata & hise_pkg::BAR1_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bar0_r <= 32'h00000000;
      bar1_r <= 32'h00000000;
    end else begin
      bar0_r <= bar0_nxt;
      bar1_r <= bar1_nxt;
    end
  end

  always_comb begin
    if (cfg_off == hise_pkg::CFG_OFF_ID) begin
      cfg_rdata = {hise_pkg::CFG_DEVICE_ID, hise_pkg::CFG_VENDOR_ID};
    end else if (cfg_off == hise_pkg::CFG_OFF_BAR0) begin
      cfg_rdata = {bar0_r[31:4], hise_pkg::BAR_MEM32};
    end else if (cfg_off == hise_pkg::CFG_OFF_BAR1) begin
      cfg_rdata = {bar1_r[31:4], hise_pkg::BAR_MEM32};
    end else begin
      cfg_rdata = 32'h00000000;
    end
  end

  assign bar0_base = bar0_r;
  assign bar1_base = bar1_r;

endmodule : hise_cfg_hdr

// ===== rtl/hise_pkg.sv
// package: register map, field layout and carrier types of the interrupt block
package hise_pkg;

  // runtime window (region 0) and fifo window (region 1) sizes
  localparam int unsigned RT_WIN_BYTES = 256;
  localparam int unsigned FIFO_WIN_BYTES = 1048576;
  localparam int unsigned RT_AW = 8;
  localparam int unsigned FIFO_AW = 20;

  // runtime offsets
  localparam logic [7:0] OFF_INT_STAT_EN = 8'h00;
  localparam logic [7:0] OFF_BOARD_CS = 8'h04;
  localparam logic [7:0] OFF_LINK_CONTROL_REG = 8'h08;
  localparam logic [7:0] OFF_LINK_STAT = 8'h0C;
  localparam logic [7:0] OFF_PAR_FLAGS = 8'h10;
  localparam logic [7:0] OFF_RX_THRESH = 8'h14;
  localparam logic [7:0] OFF_WATCHDOG = 8'h18;
  localparam logic [7:0] OFF_WD_RSVD = 8'h1C;
  localparam logic [7:0] OFF_CH0_BASE = 8'h20;
  localparam logic [7:0] OFF_CH0_LAST = 8'h4F;
  localparam logic [7:0] OFF_CH1_BASE = 8'h50;
  localparam logic [7:0] OFF_CH1_LAST = 8'h7F;

  // interrupt register field layout
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned STAT_LSB = 0;
  localparam int unsigned EN_LSB = 16;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] EN_RESET = 8'h00;

  // source positions
  localparam int unsigned SRC_TXN0 = 0;
  localparam int unsigned SRC_TXN1 = 1;
  localparam int unsigned SRC_DMA0 = 2;
  localparam int unsigned SRC_DMA1 = 3;
  localparam int unsigned SRC_LINK_ERR = 4;
  localparam int unsigned SRC_PAR_PORT = 5;
  localparam int unsigned SRC_THRESH = 6;
  localparam int unsigned SRC_WDOG = 7;

  // configuration header (identity values arbitrary)
  localparam logic [15:0] CFG_VENDOR_ID = 16'hA5A5;
  localparam logic [15:0] CFG_DEVICE_ID = 16'h0F0F;
  localparam logic [7:0] CFG_OFF_ID = 8'h00;
  localparam logic [7:0] CFG_OFF_BAR0 = 8'h10;
  localparam logic [7:0] CFG_OFF_BAR1 = 8'h14;
  localparam logic [31:0] BAR0_MASK = 32'hFFFFFF00;
  localparam logic [31:0] BAR1_MASK = 32'hFFF00000;
  localparam logic [3:0] BAR_MEM32 = 4'h0;

  // host access kind
  typedef enum logic [1:0] {
    HISE_SP_CFG = 2'b00,
    HISE_SP_RT = 2'b01,
    HISE_SP_FIFO = 2'b10
  } hise_space_type;

  typedef struct packed {
    logic valid;
    logic write;
    hise_space_type space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hise_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } hise_rsp_type;

endpackage : hise_pkg

// ===== rtl/hise_top.sv
// runtime register front end with interrupt status and enable register
// Summary of operation
// - runtime registers are reached only by 32-bit memory cycles in region 0.
// - two regions are claimed, 256 bytes of registers and 1 MB for fifo.
// - a configuration header returns fixed vendor and device codes.
// - interrupt register sits at 0x00 and board control/status at 0x04.
// - link control at 0x08, link status at 0x0C, port flags at 0x10.
// - threshold at 0x14, watchdog at 0x18, the word at 0x1C reserved.
// - channel 0 occupies 0x20 to 0x4F and channel 1 0x50 to 0x7F.
// - bits 0 and 1 flag pending transaction channel 0 and 1 events.
// - bits 2 and 3 flag pending dma chain 0 and 1 events.
// - bit 4 flags a link error and bit 5 a parallel port event.
// - bit 6 flags fifo threshold and bit 7 watchdog expiry.
// - writing one clears a status flag, writing zero leaves it.
// - enable bits 16 to 19 gate the channel and dma sources.
// - enable bits 20 to 23 gate link, port, threshold and watchdog.
// - all flags and enables are zero after reset.
`timescale 1ns/100ps
module hise_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire hise_pkg::hise_req_type host_req,
  input wire logic [3:0] host_be,
  output hise_pkg::hise_rsp_type host_rsp,
  input wire logic [7:0] src_event,
  input wire logic [31:0] board_cs_rdata,
  input wire logic [31:0] link_control_reg_rdata,
  input wire logic [31:0] link_stat_rdata,
  input wire logic [31:0] par_flags_rdata,
  input wire logic [31:0] rx_thresh_rdata,
  input wire logic [31:0] watchdog_rdata,
  input wire logic [31:0] ch0_rdata,
  input wire logic [31:0] ch1_rdata,
  input wire logic [31:0] fifo_rdata,
  output logic [4:0] sub_sel,
  output logic [7:0] sub_off,
  output logic sub_wr,
  output logic [31:0] sub_wdata,
  output logic fifo_wr,
  output logic fifo_rd,
  output logic [19:0] fifo_off,
  output logic int_req
);

  // sub-register selects driven toward the owning blocks
  localparam logic [4:0] SEL_NONE = 5'h00;
  localparam logic [4:0] SEL_BOARD = 5'h01;
  localparam logic [4:0] SEL_LINK_CONTROL_REG = 5'h02;
  localparam logic [4:0] SEL_LINK_STAT = 5'h03;
  localparam logic [4:0] SEL_PAR = 5'h04;
  localparam logic [4:0] SEL_THRESH = 5'h05;
  localparam logic [4:0] SEL_WDOG = 5'h06;
  localparam logic [4:0] SEL_CH0 = 5'h07;
  localparam logic [4:0] SEL_CH1 = 5'h08;
  localparam logic [4:0] SEL_INT = 5'h09;

  // offset decode, used for both read mux and write strobe
  function automatic logic [4:0] decode_off(input logic [7:0] off);
    logic [4:0] s;
    s = SEL_NONE;
    if (off == hise_pkg::OFF_INT_STAT_EN) begin
      s = SEL_INT;
    end else if (off == hise_pkg::OFF_BOARD_CS) begin
      s = SEL_BOARD;
    end else if (off == hise_pkg::OFF_LINK_CONTROL_REG) begin
      s = SEL_LINK_CONTROL_REG;
    end else if (off == hise_pkg::OFF_LINK_STAT) begin
      s = SEL_LINK_STAT;
    end else if (off == hise_pkg::OFF_PAR_FLAGS) begin
      s = SEL_PAR;
    end else if (off == hise_pkg::OFF_RX_THRESH) begin
      s = SEL_THRESH;
    end else if (off == hise_pkg::OFF_WATCHDOG) begin
      s = SEL_WDOG;
    end else if (off >= hise_pkg::OFF_CH0_BASE &&
                 off <= hise_pkg::OFF_CH0_LAST) begin
      s = SEL_CH0;
    end else if (off >= hise_pkg::OFF_CH1_BASE &&
                 off <= hise_pkg::OFF_CH1_LAST) begin
      s = SEL_CH1;
    end
    // 0x1C and 0x80..0xFF fall through to none
    return s;
  endfunction : decode_off

  logic [31:0] bar0_base;
  logic [31:0] bar1_base;
  logic [31:0] cfg_rdata;
  logic cfg_wr;
  logic rt_hit;
  logic fifo_hit;
  logic full_word;
  logic [7:0] rt_off;
  logic [4:0] sel;

  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] en_r;
  logic [7:0] en_nxt;
  logic int_wr;
  logic [31:0] int_word;

  logic rsp_valid_r;
  logic rsp_valid_nxt;
  logic [31:0] rsp_data_r;
  logic [31:0] rsp_data_nxt;

  hise_cfg_hdr u_cfg (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cfg_wr(cfg_wr),
    .cfg_off(host_req.addr[7:0]),
    .cfg_wdata(host_req.wdata),
    .cfg_rdata(cfg_rdata),
    .bar0_base(bar0_base),
    .bar1_base(bar1_base)
  );

  assign cfg_wr = host_req.valid && host_req.write &&
                  host_req.space == hise_pkg::HISE_SP_CFG;
  // whole-word cycles only; partial lanes are dropped
  assign full_word = host_be == 4'hF && host_req.addr[1:0] == 2'b00;
  // region 0 is 256 bytes, region 1 is 1 MB
  assign rt_hit = host_req.valid && full_word &&
                  host_req.space == hise_pkg::HISE_SP_RT &&
                  (host_req.addr & hise_pkg::BAR0_MASK) == bar0_base;
  assign fifo_hit = host_req.valid && full_word &&
                    host_req.space == hise_pkg::HISE_SP_FIFO &&
                    (host_req.addr & hise_pkg::BAR1_MASK) == bar1_base;
  assign rt_off = host_req.addr[hise_pkg::RT_AW-1:0];
  assign sel = rt_hit ? decode_off(rt_off) : SEL_NONE;

  // strobes to the other register blocks
  assign sub_sel = (sel == SEL_INT) ? SEL_NONE : sel;
  assign sub_off = rt_off;
  assign sub_wr = host_req.write && sel != SEL_NONE && sel != SEL_INT;
  assign sub_wdata = host_req.wdata;
  assign fifo_wr = fifo_hit && host_req.write;
  assign fifo_rd = fifo_hit && !host_req.write;
  assign fifo_off = host_req.addr[hise_pkg::FIFO_AW-1:0];

  assign int_wr = sel == SEL_INT && host_req.write;

  assign int_word = {8'h00,
                     en_r,
                     8'h00,
                     stat_r};

  // per-source flag and enable logic
  generate
    for (genvar i = 0; i < hise_pkg::NUM_SRC; i++) begin : g_src
      always_comb begin
        stat_nxt[i] = stat_r[i];
        if (int_wr && host_req.wdata[hise_pkg::STAT_LSB + i]) begin
          stat_nxt[i] = 1'b0;
        end
        // new event wins over a same-cycle clear
        if (src_event[i]) begin
          stat_nxt[i] = 1'b1;
        end
        en_nxt[i] = en_r[i];
        if (int_wr) begin
          en_nxt[i] = host_req.wdata[hise_pkg::EN_LSB + i];
        end
      end
    end
  endgenerate

  // flags and enables cleared by reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= hise_pkg::STAT_RESET;
      en_r <= hise_pkg::EN_RESET;
    end else begin
      stat_r <= stat_nxt;
      en_r <= en_nxt;
    end
  end

  assign int_req = |(stat_r & en_r);

  // read answer registered one cycle after the request
  always_comb begin
    rsp_valid_nxt = host_req.valid && !host_req.write;
    rsp_data_nxt = 32'h00000000;
    if (host_req.valid && !host_req.write) begin
      if (host_req.space == hise_pkg::HISE_SP_CFG) begin
        rsp_data_nxt = cfg_rdata;
      end else if (fifo_hit) begin
        rsp_data_nxt = fifo_rdata;
      end else if (sel == SEL_INT) begin
        rsp_data_nxt = int_word;
      end else if (sel == SEL_BOARD) begin
        rsp_data_nxt = board_cs_rdata;
      end else if (sel == SEL_LINK_CONTROL_REG) begin
        rsp_data_nxt = link_control_reg_rdata;
      end else if (sel == SEL_LINK_STAT) begin
        rsp_data_nxt = link_stat_rdata;
      end else if (sel == SEL_PAR) begin
        rsp_data_nxt = par_flags_rdata;
      end else if (sel == SEL_THRESH) begin
        rsp_data_nxt = rx_thresh_rdata;
      end else if (sel == SEL_WDOG) begin
        rsp_data_nxt = watchdog_rdata;
      end else if (sel == SEL_CH0) begin
        rsp_data_nxt = ch0_rdata;
      end else if (sel == SEL_CH1) begin
        rsp_data_nxt = ch1_rdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 32'h00000000;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

  // one driver for the whole answer struct
  assign host_rsp = '{valid: rsp_valid_r, rdata: rsp_data_r};

endmodule : hise_top

// ===== tb/hise_partner.sv
// partner model: external register owners behind the runtime front end
`timescale 1ns/100ps
module hise_partner (
  input wire logic ref_clk,
  input wire logic [4:0] sub_sel,
  input wire logic fifo_rd,
  output logic [31:0] board_cs_rdata,
  output logic [31:0] link_control_reg_rdata,
  output logic [31:0] link_stat_rdata,
  output logic [31:0] par_flags_rdata,
  output logic [31:0] rx_thresh_rdata,
  output logic [31:0] watchdog_rdata,
  output logic [31:0] ch0_rdata,
  output logic [31:0] ch1_rdata,
  output logic [31:0] fifo_rdata
);
  logic [31:0] spin_r = 32'h0;
  // unselected owners show moving junk, never stale data
  always @(posedge ref_clk) spin_r <= spin_r + 32'h1;
  function automatic logic [31:0] own(input logic hit, input logic [4:0] k);
    return hit ? {8'hC3, 19'h0, k} : ~{8'hC3, 19'h0, k} ^ spin_r;
  endfunction : own
  assign board_cs_rdata = own(sub_sel == 5'd1, 5'd1);
  assign link_control_reg_rdata = own(sub_sel == 5'd2, 5'd2);
  assign link_stat_rdata = own(sub_sel == 5'd3, 5'd3);
  assign par_flags_rdata = own(sub_sel == 5'd4, 5'd4);
  assign rx_thresh_rdata = own(sub_sel == 5'd5, 5'd5);
  assign watchdog_rdata = own(sub_sel == 5'd6, 5'd6);
  assign ch0_rdata = own(sub_sel == 5'd7, 5'd7);
  assign ch1_rdata = own(sub_sel == 5'd8, 5'd8);
  assign fifo_rdata = own(fifo_rd, 5'd9);
endmodule : hise_partner

// ===== tb/hise_props.sv
// checker: port assertions of the interrupt front end
`timescale 1ns/100ps
module hise_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire hise_pkg::hise_req_type host_req,
  input wire logic [3:0] host_be,
  input wire hise_pkg::hise_rsp_type host_rsp,
  input wire logic [7:0] src_event,
  input wire logic [4:0] sub_sel,
  input wire logic [7:0] sub_off,
  input wire logic sub_wr,
  input wire logic [31:0] sub_wdata,
  input wire logic fifo_wr,
  input wire logic fifo_rd,
  input wire logic [19:0] fifo_off,
  input wire logic int_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic ok, rt, rd0, wr0;
  logic [31:0] b0_r, b1_r;
  // region bases follow the host's configuration writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      b0_r <= 32'h00000000;
      b1_r <= 32'h00000000;
    end else if (host_req.valid && host_req.write
        && host_req.space == hise_pkg::HISE_SP_CFG) begin
      if (host_req.addr[7:0] == hise_pkg::CFG_OFF_BAR0) begin
        b0_r <= host_req.wdata & hise_pkg::BAR0_MASK;
      end
      if (host_req.addr[7:0] == hise_pkg::CFG_OFF_BAR1) begin
        b1_r <= host_req.wdata & hise_pkg::BAR1_MASK;
      end
    end
  end
  // only full aligned words inside the claimed region
  assign ok = host_req.valid && host_be == 4'hF && host_req.addr[1:0] == 2'b00;
  assign rt = ok && host_req.space == hise_pkg::HISE_SP_RT
    && host_req.addr[31:8] == b0_r[31:8];
  assign rd0 = rt && !host_req.write && host_req.addr[7:0] == 8'h00;
  assign wr0 = rt && host_req.write && host_req.addr[7:0] == 8'h00;
  property p_rsp; host_req.valid && !host_req.write |=> host_rsp.valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("read not answered");
  property p_norsp; !(host_req.valid && !host_req.write) |=> !host_rsp.valid;
  endproperty
  a_norsp: assert property (p_norsp) else $error("stray answer");
  property p_irq; rd0 && src_event == 8'h00 |=>
    int_req == |(host_rsp.rdata[7:0] & host_rsp.rdata[23:16]); endproperty
  a_irq: assert property (p_irq) else $error("request level wrong");
  property p_rsvd; rd0 |=> host_rsp.rdata[15:8] == 8'h00
    && host_rsp.rdata[31:24] == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_set; src_event != 8'h00 ##1 rd0 |=> (host_rsp.rdata[7:0]
    & $past(src_event, 2)) == $past(src_event, 2); endproperty
  a_set: assert property (p_set) else $error("event flag lost");
  property p_dec; rt && host_req.addr[7:0] == 8'h04 |-> sub_sel == 5'd1;
  endproperty
  a_dec: assert property (p_dec) else $error("board decode wrong");
  property p_ch; rt && host_req.addr[7:0] inside {[8'h50:8'h7C]}
    |-> sub_sel == 5'd8; endproperty
  a_ch: assert property (p_ch) else $error("channel decode wrong");
  property p_rsv; rt && (host_req.addr[7] || host_req.addr[7:0] == 8'h1C)
    |-> sub_sel == 5'd0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved decoded");
  property p_fifo; ok && host_req.space == hise_pkg::HISE_SP_FIFO
    && host_req.addr[31:20] == b1_r[31:20] |-> fifo_rd == !host_req.write
    && fifo_wr == host_req.write
    && fifo_off == host_req.addr[19:0]; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo strobe wrong");
  property p_mask; wr0 && host_req.wdata[23:16] == 8'h00 |=> !int_req;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_w1c; wr0 && host_req.wdata[7:0] == 8'hFF && src_event == 8'h00
    |=> !int_req; endproperty
  a_w1c: assert property (p_w1c) else $error("flags not cleared");
  property p_wstb; rt && host_req.write |-> sub_off == host_req.addr[7:0]
    && sub_wdata == host_req.wdata && sub_wr == (host_req.addr[7:0] inside
    {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, [8'h20:8'h7C]}); endproperty
  a_wstb: assert property (p_wstb) else $error("write strobe wrong");
endmodule : hise_props
bind hise_top hise_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .host_req(host_req), .host_be(host_be), .host_rsp(host_rsp),
  .src_event(src_event), .sub_sel(sub_sel), .sub_off(sub_off),
  .sub_wr(sub_wr), .sub_wdata(sub_wdata), .fifo_wr(fifo_wr),
  .fifo_rd(fifo_rd), .fifo_off(fifo_off), .int_req(int_req));

// ===== tb/testbench.sv
// self-checking bench of the interrupt front end
`timescale 1ns/100ps
module testbench;
  logic ref_clk, sys_rst, sub_wr, fifo_wr, fifo_rd, int_req;
  hise_pkg::hise_req_type host_req;
  hise_pkg::hise_rsp_type host_rsp;
  logic [3:0] host_be;
  logic [7:0] src_event, sub_off, en, ev;
  logic [4:0] sub_sel;
  logic [19:0] fifo_off;
  logic [31:0] sub_wdata, q, bd, lc, ls, pf, rx, wd, c0, c1, fd;
  logic [7:0] offs [10] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h4C, 8'h7C, 8'h1C, 8'hFC};
  int num_errors = 0;
  int total_checks = 0;
  hise_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_req(host_req),
    .host_be(host_be), .host_rsp(host_rsp), .src_event(src_event),
    .board_cs_rdata(bd), .link_control_reg_rdata(lc), .link_stat_rdata(ls),
    .par_flags_rdata(pf), .rx_thresh_rdata(rx), .watchdog_rdata(wd),
    .ch0_rdata(c0), .ch1_rdata(c1), .fifo_rdata(fd), .sub_sel(sub_sel),
    .sub_off(sub_off), .sub_wr(sub_wr), .sub_wdata(sub_wdata),
    .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_off(fifo_off),
    .int_req(int_req));
  hise_partner u_far (.ref_clk(ref_clk), .sub_sel(sub_sel),
    .fifo_rd(fifo_rd), .board_cs_rdata(bd), .link_control_reg_rdata(lc),
    .link_stat_rdata(ls), .par_flags_rdata(pf), .rx_thresh_rdata(rx),
    .watchdog_rdata(wd), .ch0_rdata(c0), .ch1_rdata(c1), .fifo_rdata(fd));
  function automatic logic [31:0] pat(input int k);
    return (k == 0) ? 32'h0 : {8'hC3, 19'h0, 5'(k)};
  endfunction : pat
  function automatic logic [31:0] word(input logic [7:0] f, e);
    return {8'h00, e, 8'h00, f};
  endfunction : word
  task automatic results;
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one host cycle; a read is answered one edge later
  task automatic acc(input logic w, input logic [1:0] sp,
    input logic [31:0] a, d, input logic [3:0] be);
    @(posedge ref_clk);
    host_req <= '{1'b1, w, hise_pkg::hise_space_type'(sp), a, d};
    host_be <= be;
    src_event <= 8'h00;
    @(posedge ref_clk);
    host_req.valid <= 1'b0;
    #1 q = host_rsp.rdata;
    if (!w) chk(host_rsp.valid, 32'h1);
  endtask : acc
  task automatic pulse(input logic [7:0] e);
    @(posedge ref_clk);
    src_event <= e;
  endtask : pulse
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #50000;
    num_errors++;
    results;
  end
  initial begin
    sys_rst = 1'b1;
    host_req = '0;
    host_be = 4'h0;
    src_event = 8'h00;
    void'($urandom(70));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, 32'h0);
    chk(int_req, 32'h0);
    acc(1, 1, 32'h0, 32'hFFFFFFFF, 4'hF);
    acc(1, 1, 32'h80, 32'h0, 4'hF);
    acc(1, 1, 32'h2, 32'h0, 4'hF);
    acc(1, 1, 32'h0, 32'h0, 4'h3);
    acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, 32'h00FF0000);
    acc(0, 1, 32'h0, 32'h0, 4'h3); chk(q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, word(8'h01 << i, 8'hFF));
      chk(int_req, 32'h1);
      acc(1, 1, 32'h0, word(8'h00, 8'hFF), 4'hF);
      acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, word(8'h01 << i, 8'hFF));
      acc(1, 1, 32'h0, word(8'h01 << i, 8'hFF), 4'hF);
      chk(int_req, 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      en = 8'($urandom);
      ev = 8'($urandom);
      acc(1, 1, 32'h0, word(8'hFF, en), 4'hF);
      pulse(ev);
      acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, word(ev, en));
      chk(int_req, 32'(|(ev & en)));
    end
    // same-cycle event and clear: the event must survive
    @(posedge ref_clk);
    host_req <= '{1'b1, 1'b1, hise_pkg::HISE_SP_RT, 32'h0,
      word(8'hFF, 8'hFF)};
    src_event <= 8'h81;
    @(posedge ref_clk);
    host_req.valid <= 1'b0;
    src_event <= 8'h00;
    acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, word(8'h81, 8'hFF));
    // flags kept while every enable is off
    pulse(8'hFF);
    acc(1, 1, 32'h0, word(8'h00, 8'h00), 4'hF);
    chk(int_req, 32'h0);
    acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, word(8'hFF, 8'h00));
    acc(1, 1, 32'h0, word(8'h00, 8'h80), 4'hF);
    chk(int_req, 32'h1);
    // mid-run reset must drop live flags and enables
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk(int_req, 32'h0);
    acc(0, 1, 32'h0, 32'h0, 4'hF); chk(q, 32'h0);
    for (int i = 0; i < 10; i++) begin
      acc(1, 1, 32'(offs[i]), $urandom, 4'hF);
      acc(0, 1, 32'(offs[i]), 32'h0, 4'hF);
      chk(q, pat(i < 8 ? i + 1 : 0));
    end
    acc(0, 0, 32'h0, 32'h0, 4'hF);
    chk(q, {hise_pkg::CFG_DEVICE_ID, hise_pkg::CFG_VENDOR_ID});
    acc(1, 0, 32'h10, 32'hFFFFFFFF, 4'hF);
    acc(0, 0, 32'h10, 32'h0, 4'hF); chk(q, 32'hFFFFFF00);
    acc(0, 1, 32'h4, 32'h0, 4'hF); chk(q, 32'h0);
    acc(1, 0, 32'h10, 32'h0, 4'hF);
    acc(1, 0, 32'h14, 32'hFFFFFFFF, 4'hF);
    acc(0, 0, 32'h14, 32'h0, 4'hF); chk(q, 32'hFFF00000);
    acc(1, 0, 32'h14, 32'h0, 4'hF);
    acc(1, 2, 32'h00012344, 32'h5, 4'hF);
    acc(0, 2, 32'h000FFFFC, 32'h0, 4'hF); chk(q, pat(9));
    results;
  end
endmodule : testbench
